// *** hw/node_cfg_pkg.sv ***
`default_nettype none
package node_cfg_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned RATE_W = 2;
	localparam int unsigned SW_W   = 8;
	localparam int unsigned DIV_W  = 13;

	// Register byte offsets
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_NVM_CFG = 8'h04;
	localparam logic [7:0] REG_ACTIVE  = 8'h08;

	// Field positions
	localparam int unsigned SW_RATE_LSB   = 6;
	localparam int unsigned STS_MODE_BIT  = 8;
	localparam int unsigned STS_DONE_BIT  = 9;
	localparam int unsigned STS_ANVM_BIT  = 10;
	localparam int unsigned STS_RNVM_BIT  = 11;
	localparam int unsigned CFG_RATE_LSB  = 6;
	localparam int unsigned CFG_R232_LSB  = 8;

	// Values after reset
	localparam logic [ADDR_W-1:0] NVM_ADDR_RST   = 6'h01;
	localparam logic [RATE_W-1:0] NVM_RATE_RST   = 2'h1;
	localparam logic [RATE_W-1:0] RS232_RATE_RST = 2'h1;

	// Bit rate codes and rates in bits per second
	localparam logic [RATE_W-1:0] RATE_FROM_NVM = 2'h0;
	localparam logic [RATE_W-1:0] RATE_CODE_1   = 2'h1;
	localparam logic [RATE_W-1:0] RATE_CODE_2   = 2'h2;
	localparam logic [RATE_W-1:0] RATE_CODE_3   = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_FROM_NVM = 6'h00;
	localparam int unsigned BPS_RATE_1 = 9_600;
	localparam int unsigned BPS_RATE_2 = 38_400;
	localparam int unsigned BPS_RATE_3 = 115_200;
	localparam int unsigned DIV_RATE_2 = CLK_HZ / BPS_RATE_2;
	localparam int unsigned DIV_RATE_3 = CLK_HZ / BPS_RATE_3;

	// Cycles from reset release until the synchronised switches are sampled
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;

	typedef enum logic [0:0] {
		LOAD_WAIT = 1'b0,
		LOAD_DONE = 1'b1
	} load_state_type;
endpackage
`default_nettype wire

// *** hw/rate_tick_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface rate_tick_if;
	import node_cfg_pkg::*;
	logic [DIV_W-1:0] divisor;
	logic             tick;
	modport ctrl (output divisor, input tick);
	modport gen  (input divisor, output tick);
endinterface
`default_nettype wire

// *** hw/bit_tick_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
module bit_tick_gen
(
	input  wire logic    clk_in,
	input  wire logic    arst_n_in,
	rate_tick_if.gen     link
);
	import node_cfg_pkg::*;

	logic [DIV_W-1:0] count_r;
	logic             tick_r;

	// One-cycle enable every divisor cycles; a new divisor is compared with the running count at once
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			count_r <= '0;
			tick_r  <= 1'b0;
		end
		else if (count_r >= link.divisor - DIV_W'(1))
		begin
			count_r <= '0;
			tick_r  <= 1'b1;
		end
		else
		begin
			count_r <= count_r + DIV_W'(1);
			tick_r  <= 1'b0;
		end
	end

	assign link.tick = tick_r;

	a_tick_spacing: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(tick_r) |=> !tick_r)
		else $error("bit tick lasted more than one cycle");
endmodule // bit_tick_gen
`default_nettype wire

// *** hw/serial_node_config_select.sv ***
// Operation
// - Switches 1-6 form address, switch 1 LSB
// - Switches 7-8 form bit rate code
// - Switches apply to RS-485 only
// - Address zero selects stored address
// - Rate code zero selects stored rate
// - Codes 1,2,3 give 9.6, 38.4, 115.2 kbps
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module serial_node_config_select
#(
	parameter int unsigned DIV_RATE_1 = node_cfg_pkg::CLK_HZ / node_cfg_pkg::BPS_RATE_1
)
(
	input  wire logic                             clk_in,
	input  wire logic                             arst_n_in,
	input  wire logic [node_cfg_pkg::SW_W-1:0]    switch_in,
	input  wire logic                             select_in,
	input  wire logic                             psel_in,
	input  wire logic                             penable_in,
	input  wire logic                             pwrite_in,
	input  wire logic [7:0]                       paddr_in,
	input  wire logic [31:0]                      pwdata_in,
	output logic      [31:0]                      prdata_out,
	output logic                                  pready_out,
	output logic                                  pslverr_out,
	output logic      [node_cfg_pkg::ADDR_W-1:0]  node_addr_out,
	output logic      [node_cfg_pkg::RATE_W-1:0]  rate_code_out,
	output logic                                  rs485_mode_out,
	output logic                                  config_valid_out,
	output logic                                  bit_tick_out
);
	import node_cfg_pkg::*;

	// Divider must fit the tick counter and give a one-cycle pulse
	if (DIV_RATE_1 < 2 || DIV_RATE_1 >= (1 << DIV_W))
	begin : g_div_check
		$error("DIV_RATE_1 out of range");
	end

	load_state_type    state_r;
	logic [1:0]        settle_r;
	logic [SW_W-1:0]   sw_meta_r;
	logic [SW_W-1:0]   sw_sync_r;
	logic              sel_meta_r;
	logic              sel_sync_r;
	logic [SW_W-1:0]   sw_latch_r;
	logic              mode485_r;
	logic [ADDR_W-1:0] nvm_addr_r;
	logic [RATE_W-1:0] nvm_rate_r;
	logic [RATE_W-1:0] r232_rate_r;
	logic [ADDR_W-1:0] sw_addr;
	logic [RATE_W-1:0] sw_rate;
	logic [ADDR_W-1:0] addr_nxt;
	logic [RATE_W-1:0] rate_nxt;
	logic [DIV_W-1:0]  div_nxt;
	logic              addr_nvm;
	logic              rate_nvm;
	logic              setup;
	logic              wr_access;
	logic              mapped;
	logic [31:0]       rdata_nxt;

	rate_tick_if tick_link ();

	bit_tick_gen u_tick
	(
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.link      (tick_link.gen)
	);

	// Two-stage synchronisers for the switch and select pins
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sw_meta_r  <= '0;
			sw_sync_r  <= '0;
			sel_meta_r <= 1'b1;
			sel_sync_r <= 1'b1;
		end
		else
		begin
			sw_meta_r  <= switch_in;
			sw_sync_r  <= sw_meta_r;
			sel_meta_r <= select_in;
			sel_sync_r <= sel_meta_r;
		end
	end

	// Sample switches and select once, after the synchronisers have settled
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_r    <= LOAD_WAIT;
			settle_r   <= '0;
			sw_latch_r <= '0;
			mode485_r  <= 1'b0;
		end
		else
		begin
			case (state_r)
				LOAD_WAIT:
				begin
					if (settle_r == SETTLE_CYCLES - 2'h1)
					begin
						sw_latch_r <= sw_sync_r;
						mode485_r  <= !sel_sync_r;
						state_r    <= LOAD_DONE;
					end
					settle_r <= settle_r + 2'h1;
				end
				LOAD_DONE: state_r <= LOAD_DONE;
				default:   state_r <= LOAD_WAIT;
			endcase
		end
	end

	assign sw_addr  = sw_latch_r[ADDR_W-1:0];
	assign sw_rate  = sw_latch_r[SW_RATE_LSB +: RATE_W];
	assign addr_nvm = (sw_addr == ADDR_FROM_NVM);
	assign rate_nvm = (sw_rate == RATE_FROM_NVM);

	always_comb
	begin
		addr_nxt = addr_nvm ? nvm_addr_r : sw_addr;
		if (!mode485_r)
		begin
			addr_nxt = nvm_addr_r;
			rate_nxt = r232_rate_r;
		end
		else if (rate_nvm)
			rate_nxt = nvm_rate_r;
		else
			rate_nxt = sw_rate;
		case (rate_nxt)
			RATE_CODE_2: div_nxt = DIV_W'(DIV_RATE_2);
			RATE_CODE_3: div_nxt = DIV_W'(DIV_RATE_3);
			default:     div_nxt = DIV_W'(DIV_RATE_1);
		endcase
	end

	assign tick_link.divisor = div_nxt;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			node_addr_out    <= '0;
			rate_code_out    <= '0;
			rs485_mode_out   <= 1'b0;
			config_valid_out <= 1'b0;
			bit_tick_out     <= 1'b0;
		end
		else
		begin
			node_addr_out    <= addr_nxt;
			rate_code_out    <= rate_nxt;
			rs485_mode_out   <= mode485_r;
			config_valid_out <= (state_r == LOAD_DONE);
			bit_tick_out     <= tick_link.tick && (state_r == LOAD_DONE);
		end
	end

	// APB slave, zero wait states
	assign setup     = psel_in && !penable_in;
	assign wr_access = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
	assign mapped    = (paddr_in == REG_STATUS) || (paddr_in == REG_NVM_CFG) || (paddr_in == REG_ACTIVE);

	always_comb
	begin
		rdata_nxt = '0;
		case (paddr_in)
			REG_STATUS:
			begin
				rdata_nxt[SW_W-1:0]    = sw_latch_r;
				rdata_nxt[STS_MODE_BIT] = mode485_r;
				rdata_nxt[STS_DONE_BIT] = (state_r == LOAD_DONE);
				rdata_nxt[STS_ANVM_BIT] = addr_nvm;
				rdata_nxt[STS_RNVM_BIT] = rate_nvm;
			end
			REG_NVM_CFG:
			begin
				rdata_nxt[ADDR_W-1:0]              = nvm_addr_r;
				rdata_nxt[CFG_RATE_LSB +: RATE_W]  = nvm_rate_r;
				rdata_nxt[CFG_R232_LSB +: RATE_W]  = r232_rate_r;
			end
			REG_ACTIVE:
			begin
				rdata_nxt[ADDR_W-1:0]             = node_addr_out;
				rdata_nxt[CFG_RATE_LSB +: RATE_W] = rate_code_out;
			end
			default: rdata_nxt = '0;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= '0;
		end
		else
		begin
			pready_out  <= setup;
			pslverr_out <= setup && !mapped;
			prdata_out  <= (setup && !pwrite_in) ? rdata_nxt : '0;
		end
	end

	// Stored values that firmware loads from non-volatile memory
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			nvm_addr_r  <= NVM_ADDR_RST;
			nvm_rate_r  <= NVM_RATE_RST;
			r232_rate_r <= RS232_RATE_RST;
		end
		else if (wr_access && paddr_in == REG_NVM_CFG)
		begin
			nvm_addr_r  <= pwdata_in[ADDR_W-1:0];
			nvm_rate_r  <= pwdata_in[CFG_RATE_LSB +: RATE_W];
			r232_rate_r <= pwdata_in[CFG_R232_LSB +: RATE_W];
		end
	end

	a_addr_switch: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(state_r == LOAD_DONE && mode485_r && !addr_nvm) |=> node_addr_out == sw_latch_r[ADDR_W-1:0])
		else $error("node address does not follow switches");
	a_rate_switch: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(state_r == LOAD_DONE && mode485_r && !rate_nvm) |=> rate_code_out == sw_latch_r[7:6])
		else $error("rate code does not follow switches");
	a_rs232_ignore: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!mode485_r |=> (rate_code_out == $past(r232_rate_r)) && (node_addr_out == $past(nvm_addr_r)))
		else $error("switches leaked into RS-232 setting");
	a_addr_nvm: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(mode485_r && sw_latch_r[ADDR_W-1:0] == 6'h00) |=> node_addr_out == $past(nvm_addr_r))
		else $error("zero address did not select stored address");
	a_rate_nvm: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(mode485_r && sw_latch_r[7:6] == 2'h0) |=> rate_code_out == $past(nvm_rate_r))
		else $error("zero rate did not select stored rate");
	a_rate_divisor: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(rate_nxt == 2'h3) |-> tick_link.divisor == 13'h1b2)
		else $error("wrong divisor for 115.2 kbps");
	a_latch_once: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(state_r == LOAD_DONE) |=> $stable(sw_latch_r) && $stable(mode485_r) && state_r == LOAD_DONE)
		else $error("switch latch changed after load");
	a_load_time: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(arst_n_in) |-> ##[0:4] state_r == LOAD_DONE)
		else $error("switches not latched in time");
endmodule // serial_node_config_select
`default_nettype wire

// *** test/switch_panel.sv ***
`timescale 1ns/1ns
`default_nettype none
module switch_panel
(
	input  wire logic [7:0] want_in,
	input  wire logic       sel_in,
	output logic      [7:0] switch_out,
	output logic            select_out
);
	// Switch contacts and the interface select strap held by the installer
	assign switch_out = want_in;
	assign select_out = sel_in;
endmodule // switch_panel
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import node_cfg_pkg::*;
	logic        clk_in = 0, arst_n_in = 0, psel = 0, pen = 0, pwr = 0, sel, seld = 0;
	logic [7:0]  sw, swd = 0, paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr, cv, tick, mode;
	logic [5:0]  na;
	logic [1:0]  rc;
	logic [32:0] ev;
	logic [32:0] exp_q[$];
	logic [7:0]  s;
	int          err_count = 0, check_count = 0, cyc = 0, seed = 98119;

	serial_node_config_select #(.DIV_RATE_1(8)) serial_node_config_select_inst (.clk_in(clk_in),
		.arst_n_in(arst_n_in), .switch_in(sw), .select_in(sel), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .node_addr_out(na), .rate_code_out(rc),
		.rs485_mode_out(mode), .config_valid_out(cv), .bit_tick_out(tick));
	switch_panel switch_panel_inst (.want_in(swd), .sel_in(seld), .switch_out(sw), .select_out(sel));

	initial forever #10 clk_in = ~clk_in;

	task automatic close_out;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] v);
		check_count++;
		if (v !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, v);
		end
	endtask

	// Read expectations go to the queue; the monitor compares them at the access edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
		@(posedge clk_in);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge clk_in);
		pen <= 1;
		// Wait until pready is high; the bench timeout ends it if pready never comes
		do
		begin
			@(posedge clk_in);
		end
		while (pready !== 1'b1);
		psel <= 0;
		pen <= 0;
	endtask

	always @(posedge clk_in)
		if (psel && pen && pready === 1'b1 && !pwr)
		begin
			ev = exp_q.pop_front();
			chk("prdata", ev[31:0], prdata);
			chk("pslverr", ev[32], pslverr);
		end

	// Switches move after the latch point; the decoded values must not follow
	task automatic boot(logic [7:0] v, logic sl);
		@(posedge clk_in);
		arst_n_in <= 0;
		swd <= v;
		seld <= sl;
		repeat (20) @(posedge clk_in);
		arst_n_in <= 1;
		repeat (6) @(posedge clk_in);
		swd <= ~v;
		repeat (3) @(posedge clk_in);
	endtask

	task automatic verify(logic [7:0] v, logic sl, logic [5:0] an, logic [1:0] rn, logic [1:0] r2);
		logic [5:0] ea;
		logic [1:0] er;
		int         n;
		int         d;
		repeat (2) @(posedge clk_in);
		ea = (sl || v[5:0] == 0) ? an : v[5:0];
		er = sl ? r2 : (v[7:6] == 0 ? rn : v[7:6]);
		chk("node_addr", ea, na);
		chk("rate_code", er, rc);
		chk("rs485_mode", !sl, mode);
		chk("config_valid", 1, cv);
		apb(0, REG_ACTIVE, 0, {25'h0, er, ea});
		if (!sl)
			apb(0, REG_STATUS, 0, {21'h0, v[7:6] == 0, v[5:0] == 0, 2'h3, v});
		d = er == 2 ? DIV_RATE_2 : er == 3 ? DIV_RATE_3 : 8;
		n = 0;
		while (tick !== 1'b1 && n < 3000)
		begin
			@(posedge clk_in);
			n++;
		end
		@(posedge clk_in);
		n = 1;
		while (tick !== 1'b1 && n < 3000)
		begin
			@(posedge clk_in);
			n++;
		end
		chk("tick_period", d, n);
	endtask

	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			err_count++;
			close_out;
		end
	end

	initial
	begin
		for (int i = 0; i < 7; i++)
		begin
			s = $random(seed);
			s[7:6] = i[1:0];
			if (i == 4)
				s[5:0] = 0;
			boot(s, i > 4);
			verify(s, i > 4, 6'h01, 2'h1, 2'h1);
		end
		// Stored values after reset, then firmware loads new ones
		boot(8'h00, 0);
		apb(0, REG_NVM_CFG, 0, {23'h0, 10'h141});
		apb(1, REG_NVM_CFG, 32'h0000_02ea, 0);
		apb(0, REG_NVM_CFG, 0, {23'h0, 10'h2ea});
		verify(8'h00, 0, 6'h2a, 2'h3, 2'h2);
		apb(1, REG_ACTIVE, 32'hffff_ffff, 0);
		apb(0, REG_ACTIVE, 0, {25'h0, 2'h3, 6'h2a});
		apb(0, 8'h0c, 0, {1'b1, 32'h0});
		boot(8'hc5, 1);
		apb(1, REG_NVM_CFG, 32'h0000_0217, 0);
		verify(8'hc5, 1, 6'h17, 2'h0, 2'h2);
		close_out;
	end
endmodule // testbench
`default_nettype wire
